// >>> bench/sra_line_model.sv
// Line receiver and framer model feeding the alarm block
module sra_line_model (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Fault controls
	input  wire logic        clk_stop,
	input  wire logic        data_stop,
	input  wire logic        h4_hold,
	input  wire logic        k1_vary,
	// Line and overhead
	output logic             line_clk,
	output logic [7:0]       line_data,
	output logic             strobe,
	output logic [7:0]       k1,
	output logic [23:0]      h4
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cyc_q;
	logic [1:0] mf_q;
	// Same multiframe count on all three channels
	assign h4 = {6'h00, mf_q, 6'h00, mf_q, 6'h00, mf_q};
	// Bytes move only after the strobe edge that sampled them
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cyc_q <= 4'h0;
			mf_q <= 2'h0;
			k1 <= 8'h00;
			strobe <= 1'b0;
			line_clk <= 1'b0;
			line_data <= 8'h00;
		end else begin
			cyc_q <= cyc_q + 4'h1;
			strobe <= (cyc_q == 4'hF);
			if (strobe && !h4_hold) begin
				mf_q <= mf_q + 2'h1;
			end
			if (strobe && k1_vary) begin
				k1 <= k1 + 8'h01;
			end
			// A stopped line holds still, which is the fault itself
			if (!clk_stop) begin
				line_clk <= ~line_clk;
			end
			if (!data_stop) begin
				line_data <= line_data + 8'h01;
			end
		end
	end
endmodule : sra_line_model

// >>> bench/sra_rx_alarm_status_test.sv
// Self-checking bench for the receive alarm and status block
`define CHK(got, want) \
	begin \
		num_checks++; \
		if ((got) !== (want)) begin \
			err_total++; \
			$display("mismatch at %0t: read %h want %h", $time, got, want); \
		end \
	end

module sra_rx_alarm_status_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock;
	logic        reset_n;
	logic        clk_stop, data_stop, h4_hold, k1_vary;
	logic        los_pin, oof_pin, lof_pin;
	logic        line_clk, strobe, rd_s, wr_s, rd_d;
	logic [7:0]  line_data, k1, k2, wdata, rdata;
	logic [23:0] h1, h2, h4;
	logic [9:0]  addr;
	logic [7:0]  exp_q[$];
	logic [7:0]  exp_v;
	logic [3:0]  flag_c[5] = '{4'h9, 4'h8, 4'h1, 4'hD, 4'hB};
	int          err_total;
	int          num_checks;
	int          cyc;

	sra_line_model line_u (.clock(clock), .reset_n(reset_n),
		.clk_stop(clk_stop), .data_stop(data_stop), .h4_hold(h4_hold),
		.k1_vary(k1_vary), .line_clk(line_clk), .line_data(line_data),
		.strobe(strobe), .k1(k1), .h4(h4));

	// Short data-idle count keeps the run brief
	sra_rx_alarm_status #(.LOS_CYC(20)) dut_u (.clock(clock),
		.reset_n(reset_n), .rx_line_clock_in(line_clk),
		.rx_line_data_in(line_data), .framer_signal_lost_pin(los_pin),
		.framer_out_of_frame_pin(oof_pin), .framer_frame_lost_pin(lof_pin),
		.frame_strobe(strobe), .k1_byte(k1), .k2_byte(k2), .h1_bytes(h1),
		.h2_bytes(h2), .h4_bytes(h4), .cpu_addr(addr), .cpu_read(rd_s),
		.cpu_write(wr_s), .cpu_wdata(wdata), .cpu_rdata(rdata));

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : wait_cyc

	task automatic frames(input int n);
		repeat (n) @(posedge strobe);
		wait_cyc(2);
	endtask : frames

	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clock);
		rd_s <= 1'b0;
		@(posedge clock);
	endtask : rd

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clock);
		wr_s <= 1'b0;
		@(posedge clock);
	endtask : wr

	// Read data lands one edge after the strobe and is checked on the edge after that
	always @(posedge clock) begin
		if (rd_d) begin
			// Pop once; the macro names its arguments twice
			exp_v = exp_q.pop_front();
			`CHK(rdata, exp_v)
		end
		rd_d <= rd_s;
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			report_and_stop();
		end
	end

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	initial begin
		void'($urandom(94));
		{reset_n, clk_stop, data_stop, h4_hold, k1_vary} = 5'h00;
		{los_pin, oof_pin, lof_pin, rd_s, wr_s} = 5'h00;
		{k2, wdata, addr} = 26'h0;
		h1 = 24'h686868;
		h2 = 24'($urandom);
		wait_cyc(16);
		reset_n <= 1'b1;
		frames(3);
		for (int a = 0; a < 5; a++) begin
			rd(10'h3D0 + 10'(a), 8'h00);
		end
		wr(10'h3D0, 8'hFF);
		rd(10'h3D0, 8'h00);
		wr(10'h3E2, 8'h5A);
		rd(10'h3E2, 8'h5A);
		wr(10'h3E2, 8'h00);
		$display("map test done");
		// Framer pins are steady levels
		{los_pin, oof_pin, lof_pin} <= 3'h7;
		wait_cyc(3);
		rd(10'h3D0, 8'h70);
		{los_pin, oof_pin, lof_pin} <= 3'h0;
		wait_cyc(3);
		rd(10'h3D0, 8'h00);
		rd(10'h3D1, 8'h70);
		rd(10'h3D1, 8'h00);
		$display("pin test done");
		clk_stop <= 1'b1;
		wait_cyc(118);
		rd(10'h3D0, 8'h00);
		wait_cyc(280);
		rd(10'h3D0, 8'h80);
		clk_stop <= 1'b0;
		wait_cyc(3);
		rd(10'h3D0, 8'h00);
		rd(10'h3D1, 8'h80);
		oof_pin <= 1'b1;
		data_stop <= 1'b1;
		wait_cyc(30);
		rd(10'h3D0, 8'h20);
		oof_pin <= 1'b0;
		wait_cyc(30);
		rd(10'h3D0, 8'h40);
		data_stop <= 1'b0;
		wait_cyc(3);
		rd(10'h3D0, 8'h00);
		rd(10'h3D1, 8'h60);
		$display("line test done");
		k2 <= 8'h07;
		frames(4);
		rd(10'h3D0, 8'h00);
		frames(1);
		rd(10'h3D0, 8'h08);
		k2 <= 8'h06;
		frames(4);
		rd(10'h3D0, 8'h08);
		rd(10'h3D2, 8'h00);
		frames(1);
		rd(10'h3D0, 8'h00);
		rd(10'h3D2, 8'h08);
		k2 <= 8'h00;
		frames(5);
		rd(10'h3D2, 8'h00);
		rd(10'h3D1, 8'h08);
		rd(10'h3D3, 8'h08);
		$display("k2 test done");
		h1[15:8] <= 8'hFF;
		h2[15:8] <= 8'hFF;
		frames(2);
		rd(10'h3D0, 8'h00);
		frames(1);
		rd(10'h3D0, 8'h02);
		h1[15:8] <= 8'h98;
		h2 <= 24'($urandom);
		frames(1);
		rd(10'h3D0, 8'h00);
		rd(10'h3D1, 8'h02);
		for (int i = 0; i < 8; i++) begin
			// Whole word, so h1 gets one assignment per time step
			h1 <= {flag_c[i % 5], 4'h8, 16'h6868};
			frames(1);
			if (i == 6) begin
				rd(10'h3D2, 8'h00);
			end
		end
		rd(10'h3D2, 8'h40);
		wr(10'h3E2, 8'h04);
		rd(10'h3D2, 8'h00);
		h1[23:16] <= 8'h68;
		frames(3);
		wr(10'h3E2, 8'h00);
		rd(10'h3D2, 8'h00);
		rd(10'h3D3, 8'h40);
		wr(10'h3E1, 8'h20);
		h1[7:0] <= 8'h60;
		frames(7);
		rd(10'h3D2, 8'h00);
		frames(1);
		rd(10'h3D2, 8'h10);
		h1[7:0] <= 8'h68;
		frames(3);
		rd(10'h3D2, 8'h00);
		wr(10'h3E1, 8'h00);
		rd(10'h3D3, 8'h10);
		$display("pointer test done");
		h4_hold <= 1'b1;
		frames(4);
		rd(10'h3D2, 8'h00);
		frames(1);
		rd(10'h3D2, 8'h07);
		h4_hold <= 1'b0;
		frames(2);
		rd(10'h3D2, 8'h07);
		frames(8);
		rd(10'h3D2, 8'h00);
		rd(10'h3D3, 8'h07);
		k1_vary <= 1'b1;
		frames(10);
		rd(10'h3D2, 8'h00);
		frames(4);
		rd(10'h3D2, 8'h80);
		k1_vary <= 1'b0;
		frames(3);
		rd(10'h3D2, 8'h00);
		rd(10'h3D3, 8'h80);
		$display("frame test done");
		report_and_stop();
	end
endmodule : sra_rx_alarm_status_test

// >>> hdl/sra_pkg.sv
// Constants for the receive alarm and status block
package sra_pkg;
	// Microprocessor port
	localparam int         ADDR_W       = 10;
	localparam int         DATA_W       = 8;
	localparam logic [9:0] ALARM0_LIVE  = 10'h3D0;
	localparam logic [9:0] ALARM0_LATCH = 10'h3D1;
	localparam logic [9:0] ALARM1_LIVE  = 10'h3D2;
	localparam logic [9:0] ALARM1_LATCH = 10'h3D3;
	localparam logic [9:0] CTRL_MODE    = 10'h3E1;
	localparam logic [9:0] CTRL_CONCAT  = 10'h3E2;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam int         SDH_MODE_BIT = 5;
	localparam int         CONCAT2_BIT  = 1;
	localparam int         CONCAT3_BIT  = 2;
	// Timing
	localparam int         CLK_PERIOD_NS = 4;
	localparam int         LOC_TIME_NS   = 1000;
	localparam int         LOS_TIME_US   = 125;
	localparam int         LOC_W         = 9;
	localparam logic [8:0] LOC_CYC       =
		LOC_W'((LOC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int         LOS_CYC_DEF   =
		(LOS_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Frame persistence counts
	localparam int         FRAME_W      = 4;
	localparam logic [3:0] LAIS_FRAMES  = 4'h5;
	localparam logic [3:0] FERF_FRAMES  = 4'h5;
	localparam logic [3:0] PAIS_FRAMES  = 4'h3;
	localparam logic [3:0] VALID_FRAMES = 4'h3;
	localparam logic [3:0] LOP_FRAMES   = 4'h8;
	localparam logic [3:0] LOM_FRAMES   = 4'h4;
	localparam logic [3:0] APS_MATCH    = 4'h3;
	localparam logic [3:0] APS_WINDOW   = 4'hC;
	// Overhead patterns
	localparam logic [2:0]  K2_AIS     = 3'h7;
	localparam logic [2:0]  K2_RDI     = 3'h6;
	localparam logic [15:0] PTR_AIS    = 16'hFFFF;
	localparam logic [9:0]  PTR_MAX    = 10'h30E;
	localparam logic [1:0]  SS_SDH     = 2'h2;
	localparam logic [3:0]  FLAG_EXACT = 4'h9;
	localparam logic [3:0]  FLAG_ERR_A = 4'h8;
	localparam logic [3:0]  FLAG_ERR_B = 4'h1;
	localparam logic [3:0]  FLAG_ERR_C = 4'hD;
	localparam logic [3:0]  FLAG_ERR_D = 4'hB;
	localparam logic [1:0]  MF_LAST    = 2'h3;
	localparam int          CHANNELS   = 3;
endpackage : sra_pkg

// >>> hdl/sra_rx_alarm_status.sv
// Receive alarm detection with live and latched status registers
// Summary of operation
// - Clock lost after 1000 ns without edges
// - Signal lost on pin, or on idle data while the out-of-frame pin is low
// - Out-of-frame bit follows framer pin
// - Loss-of-frame bit follows framer pin
// - Line AIS: K2 ones, five frames
// - Path AIS: all-ones pointer, three frames
// - Even address live, odd latched, read-clears
// - APS fail: no triple match in 12
// - Pointer lost after eight bad frames
// - Concatenation bits force channel 2/3 pointer loss clear
// - Channel 1 SDH mode checks SS bits
// - Far-end failure: K2 110, five frames
// - Multiframe lost after four H4 misses
// - Multiframe regained on 00,01,10,11 run
// - New data flag: 1001 or one-bit errors
module sra_rx_alarm_status #(
	parameter int LOS_CYC = sra_pkg::LOS_CYC_DEF
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Receive line
	input  wire logic        rx_line_clock_in,
	input  wire logic [7:0]  rx_line_data_in,
	// Framer indications, steady levels
	input  wire logic        framer_signal_lost_pin,
	input  wire logic        framer_out_of_frame_pin,
	input  wire logic        framer_frame_lost_pin,
	// Overhead bytes, valid on frame_strobe
	input  wire logic        frame_strobe,
	input  wire logic [7:0]  k1_byte,
	input  wire logic [7:0]  k2_byte,
	input  wire logic [23:0] h1_bytes,
	input  wire logic [23:0] h2_bytes,
	input  wire logic [23:0] h4_bytes,
	// Microprocessor port
	input  wire logic [9:0]  cpu_addr,
	input  wire logic        cpu_read,
	input  wire logic        cpu_write,
	input  wire logic [7:0]  cpu_wdata,
	output logic      [7:0]  cpu_rdata
);
	localparam int LOS_W = $clog2(LOS_CYC + 1);
	localparam int LOC_W = sra_pkg::LOC_W;

	function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
		hit = (a == r);
	endfunction : hit

	function automatic logic is_new_data(input logic [3:0] f);
		is_new_data = (f == sra_pkg::FLAG_EXACT) ||
			(f == sra_pkg::FLAG_ERR_A) || (f == sra_pkg::FLAG_ERR_B) ||
			(f == sra_pkg::FLAG_ERR_C) || (f == sra_pkg::FLAG_ERR_D);
	endfunction : is_new_data

	function automatic logic [3:0] sat(input logic [3:0] c,
		input logic [3:0] lim);
		sat = (c >= lim) ? lim : c + 4'h1;
	endfunction : sat

	// Line clock and data activity
	logic             clk_prev_q, clk_prev_d;
	logic [7:0]       data_prev_q, data_prev_d;
	logic [LOC_W-1:0] loc_cnt_q, loc_cnt_d;
	logic [LOS_W-1:0] los_cnt_q, los_cnt_d;
	logic             loc_q, loc_d;
	logic             los_data_q, los_data_d;
	logic             los_q, los_d;
	logic             oof_q, oof_d;
	logic             lof_q, lof_d;
	logic             clk_edge;
	logic             data_edge;

	always_comb begin
		clk_edge = rx_line_clock_in != clk_prev_q;
		data_edge = rx_line_data_in != data_prev_q;
		clk_prev_d = rx_line_clock_in;
		data_prev_d = rx_line_data_in;
		loc_cnt_d = clk_edge ? '0 : (loc_cnt_q == sra_pkg::LOC_CYC) ?
			loc_cnt_q : loc_cnt_q + 1'b1;
		loc_d = !clk_edge && (loc_cnt_d == sra_pkg::LOC_CYC);
		los_cnt_d = data_edge ? '0 : (los_cnt_q == LOS_W'(LOS_CYC)) ?
			los_cnt_q : los_cnt_q + 1'b1;
		los_data_d = los_data_q;
		if (data_edge) begin
			los_data_d = 1'b0;
		end else if (los_cnt_d == LOS_W'(LOS_CYC) &&
			!framer_out_of_frame_pin) begin
			los_data_d = 1'b1;
		end
		los_d = framer_signal_lost_pin || los_data_d;
		oof_d = framer_out_of_frame_pin;
		lof_d = framer_frame_lost_pin;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			clk_prev_q <= 1'b0;
			data_prev_q <= 8'h00;
			loc_cnt_q <= '0;
			los_cnt_q <= '0;
			loc_q <= 1'b0;
			los_data_q <= 1'b0;
			los_q <= 1'b0;
			oof_q <= 1'b0;
			lof_q <= 1'b0;
		end else begin
			clk_prev_q <= clk_prev_d;
			data_prev_q <= data_prev_d;
			loc_cnt_q <= loc_cnt_d;
			los_cnt_q <= los_cnt_d;
			loc_q <= loc_d;
			los_data_q <= los_data_d;
			los_q <= los_d;
			oof_q <= oof_d;
			lof_q <= lof_d;
		end
	end

	// Line overhead: K1-K2 alarms
	logic [3:0]  lais_cnt_q, lais_cnt_d, ferf_cnt_q, ferf_cnt_d;
	logic [3:0]  aps_run_q, aps_run_d, aps_win_q, aps_win_d;
	logic        lais_q, lais_d, ferf_q, ferf_d, aps_q, aps_d;
	logic [15:0] k_prev_q, k_prev_d;
	logic        lais_hit, ferf_hit;

	always_comb begin
		lais_hit = k2_byte[2:0] == sra_pkg::K2_AIS;
		ferf_hit = k2_byte[2:0] == sra_pkg::K2_RDI;
		lais_cnt_d = lais_cnt_q;
		ferf_cnt_d = ferf_cnt_q;
		lais_d = lais_q;
		ferf_d = ferf_q;
		aps_run_d = aps_run_q;
		aps_win_d = aps_win_q;
		aps_d = aps_q;
		k_prev_d = k_prev_q;
		if (frame_strobe) begin
			// Count frames disagreeing with the present state
			lais_cnt_d = (lais_hit != lais_q) ? lais_cnt_q + 4'h1 : 4'h0;
			if (lais_cnt_d == sra_pkg::LAIS_FRAMES) begin
				lais_d = !lais_q;
				lais_cnt_d = 4'h0;
			end
			ferf_cnt_d = (ferf_hit != ferf_q) ? ferf_cnt_q + 4'h1 : 4'h0;
			if (ferf_cnt_d == sra_pkg::FERF_FRAMES) begin
				ferf_d = !ferf_q;
				ferf_cnt_d = 4'h0;
			end
			k_prev_d = {k1_byte, k2_byte};
			aps_run_d = ({k1_byte, k2_byte} == k_prev_q) ?
				sat(aps_run_q, sra_pkg::APS_MATCH) : 4'h1;
			if (aps_run_d == sra_pkg::APS_MATCH) begin
				aps_win_d = 4'h0;
				aps_d = 1'b0;
			end else begin
				aps_win_d = sat(aps_win_q, sra_pkg::APS_WINDOW);
				if (aps_win_d == sra_pkg::APS_WINDOW) begin
					aps_d = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lais_cnt_q <= 4'h0;
			ferf_cnt_q <= 4'h0;
			lais_q <= 1'b0;
			ferf_q <= 1'b0;
			aps_run_q <= 4'h0;
			aps_win_q <= 4'h0;
			aps_q <= 1'b0;
			k_prev_q <= 16'h0000;
		end else begin
			lais_cnt_q <= lais_cnt_d;
			ferf_cnt_q <= ferf_cnt_d;
			lais_q <= lais_d;
			ferf_q <= ferf_d;
			aps_run_q <= aps_run_d;
			aps_win_q <= aps_win_d;
			aps_q <= aps_d;
			k_prev_q <= k_prev_d;
		end
	end

	// Control registers
	logic [7:0] ctrl_mode_q, ctrl_mode_d, ctrl_concat_q, ctrl_concat_d;
	logic [2:0] concat_clr;
	wire logic [2:0] pais, lop, lom;

	assign concat_clr = {ctrl_concat_q[sra_pkg::CONCAT3_BIT],
		ctrl_concat_q[sra_pkg::CONCAT2_BIT], 1'b0};

	// Per-channel path alarms; concatenation clears only the pointer loss of channels 2 and 3
	for (genvar i = 0; i < sra_pkg::CHANNELS; i++) begin : g_ch
		logic [7:0] h1, h2;
		logic [1:0] h4lo;
		logic [9:0] ptr;
		logic       new_data, ais, ss_bad, in_range, valid, flag_ok, seq_ok;
		logic [3:0] valid_run_q, valid_run_d, ais_run_q, ais_run_d;
		logic [3:0] bad_run_q, bad_run_d, miss_q, miss_d, order_q, order_d;
		logic [1:0] h4_prev_q, h4_prev_d;
		logic       pais_q, pais_d, lop_q, lop_d, lom_q, lom_d;

		always_comb begin
			h1 = h1_bytes[8*i +: 8];
			h2 = h2_bytes[8*i +: 8];
			h4lo = h4_bytes[8*i +: 2];
			ptr = {h1[1:0], h2};
			new_data = is_new_data(h1[7:4]);
			ais = {h1, h2} == sra_pkg::PTR_AIS;
			ss_bad = (i == 0) && ctrl_mode_q[sra_pkg::SDH_MODE_BIT] &&
				(h1[3:2] != sra_pkg::SS_SDH);
			in_range = ptr <= sra_pkg::PTR_MAX;
			valid = !new_data && !ais && in_range && !ss_bad;
			flag_ok = new_data && in_range && !ss_bad;
			seq_ok = h4lo == h4_prev_q + 2'h1;
			valid_run_d = valid_run_q;
			ais_run_d = ais_run_q;
			bad_run_d = bad_run_q;
			miss_d = miss_q;
			order_d = order_q;
			h4_prev_d = h4_prev_q;
			pais_d = pais_q;
			lop_d = lop_q;
			lom_d = lom_q;
			if (frame_strobe) begin
				valid_run_d = valid ? sat(valid_run_q, sra_pkg::VALID_FRAMES)
					: 4'h0;
				ais_run_d = ais ? sat(ais_run_q, sra_pkg::PAIS_FRAMES) : 4'h0;
				// All-ones is path AIS, not a pointer loss
				bad_run_d = (!valid && !ais) ?
					sat(bad_run_q, sra_pkg::LOP_FRAMES) : 4'h0;
				if (ais_run_d == sra_pkg::PAIS_FRAMES) begin
					pais_d = 1'b1;
				end else if (flag_ok ||
					valid_run_d == sra_pkg::VALID_FRAMES) begin
					pais_d = 1'b0;
				end
				if (bad_run_d == sra_pkg::LOP_FRAMES) begin
					lop_d = 1'b1;
				end else if (valid_run_d == sra_pkg::VALID_FRAMES) begin
					lop_d = 1'b0;
				end
				h4_prev_d = h4lo;
				miss_d = seq_ok ? 4'h0 : sat(miss_q, sra_pkg::LOM_FRAMES);
				order_d = (h4lo == 2'h0) ? 4'h1 :
					(seq_ok && order_q != 4'h0) ?
					sat(order_q, sra_pkg::LOM_FRAMES) : 4'h0;
				if (lom_q) begin
					lom_d = order_d != sra_pkg::LOM_FRAMES;
				end else begin
					lom_d = miss_d == sra_pkg::LOM_FRAMES;
				end
			end
			if (concat_clr[i]) begin
				lop_d = 1'b0;
			end
		end

		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				valid_run_q <= 4'h0;
				ais_run_q <= 4'h0;
				bad_run_q <= 4'h0;
				miss_q <= 4'h0;
				order_q <= 4'h0;
				h4_prev_q <= 2'h0;
				pais_q <= 1'b0;
				lop_q <= 1'b0;
				lom_q <= 1'b0;
			end else begin
				valid_run_q <= valid_run_d;
				ais_run_q <= ais_run_d;
				bad_run_q <= bad_run_d;
				miss_q <= miss_d;
				order_q <= order_d;
				h4_prev_q <= h4_prev_d;
				pais_q <= pais_d;
				lop_q <= lop_d;
				lom_q <= lom_d;
			end
		end

		assign pais[i] = pais_q;
		assign lop[i] = lop_q;
		assign lom[i] = lom_q;

		concat_clear_a: assert property (@(posedge clock)
			disable iff (!reset_n) concat_clr[i] |=> !lop_q)
			else $error("pointer loss not forced clear by concatenation");
		lom_regain_a: assert property (@(posedge clock)
			disable iff (!reset_n) $fell(lom_q) |->
			$past(order_q) == 4'h3 && $past(h4lo) == sra_pkg::MF_LAST)
			else $error("multiframe regained without full sequence");
	end

	// Status and control register file
	logic [7:0] live0, live1;
	logic [7:0] prev0_q, prev0_d, prev1_q, prev1_d;
	logic [7:0] latch0_q, latch0_d, latch1_q, latch1_d;
	logic [7:0] rdata_q, rdata_d;
	logic       clr0, clr1;

	assign live0 = {loc_q, los_q, oof_q, lof_q, lais_q, pais};
	assign live1 = {aps_q, lop, ferf_q, lom};
	assign cpu_rdata = rdata_q;

	always_comb begin
		clr0 = cpu_read && hit(cpu_addr, sra_pkg::ALARM0_LATCH);
		clr1 = cpu_read && hit(cpu_addr, sra_pkg::ALARM1_LATCH);
		prev0_d = live0;
		prev1_d = live1;
		// A new entry in the read cycle survives the clear
		latch0_d = (latch0_q & ~{8{clr0}}) | (live0 & ~prev0_q);
		latch1_d = (latch1_q & ~{8{clr1}}) | (live1 & ~prev1_q);
		ctrl_mode_d = ctrl_mode_q;
		ctrl_concat_d = ctrl_concat_q;
		if (cpu_write && hit(cpu_addr, sra_pkg::CTRL_MODE)) begin
			ctrl_mode_d = cpu_wdata;
		end
		if (cpu_write && hit(cpu_addr, sra_pkg::CTRL_CONCAT)) begin
			ctrl_concat_d = cpu_wdata;
		end
		rdata_d = rdata_q;
		if (cpu_read) begin
			rdata_d = hit(cpu_addr, sra_pkg::ALARM0_LIVE) ? live0 :
				clr0 ? latch0_q :
				hit(cpu_addr, sra_pkg::ALARM1_LIVE) ? live1 :
				clr1 ? latch1_q :
				hit(cpu_addr, sra_pkg::CTRL_MODE) ? ctrl_mode_q :
				hit(cpu_addr, sra_pkg::CTRL_CONCAT) ? ctrl_concat_q : 8'h00;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prev0_q <= 8'h00;
			prev1_q <= 8'h00;
			latch0_q <= 8'h00;
			latch1_q <= 8'h00;
			ctrl_mode_q <= sra_pkg::CTRL_RESET;
			ctrl_concat_q <= sra_pkg::CTRL_RESET;
			rdata_q <= 8'h00;
		end else begin
			prev0_q <= prev0_d;
			prev1_q <= prev1_d;
			latch0_q <= latch0_d;
			latch1_q <= latch1_d;
			ctrl_mode_q <= ctrl_mode_d;
			ctrl_concat_q <= ctrl_concat_d;
			rdata_q <= rdata_d;
		end
	end

	loc_set_a: assert property (@(posedge clock) disable iff (!reset_n)
		(loc_cnt_q == sra_pkg::LOC_CYC - 9'h1 && !clk_edge) |=> loc_q)
		else $error("clock loss not declared");
	loc_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
		clk_edge |=> !loc_q)
		else $error("clock loss not cleared on edge");
	los_pin_a: assert property (@(posedge clock) disable iff (!reset_n)
		framer_signal_lost_pin |=> los_q)
		else $error("signal loss pin not reflected");
	oof_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
		1'b1 |=> oof_q == $past(framer_out_of_frame_pin))
		else $error("out of frame does not follow pin");
	lof_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
		1'b1 |=> lof_q == $past(framer_frame_lost_pin))
		else $error("loss of frame does not follow pin");
	lais_enter_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(lais_q) |-> $past(frame_strobe) &&
		$past(lais_cnt_q) == 4'h4 && $past(k2_byte[2:0]) == sra_pkg::K2_AIS)
		else $error("line AIS raised without five frames");
	ferf_enter_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(ferf_q) |-> $past(ferf_cnt_q) == 4'h4 &&
		$past(k2_byte[2:0]) == sra_pkg::K2_RDI)
		else $error("far-end failure raised without five frames");
	aps_enter_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(aps_q) |-> $past(aps_win_q) == 4'hB)
		else $error("APS failure raised off the window");
	latch_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(lais_q) |=> latch0_q[3])
		else $error("latched line AIS not set");
	read_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
		(clr1 && live1 == prev1_q) |=> latch1_q == 8'h00)
		else $error("latched register not cleared by read");
endmodule : sra_rx_alarm_status
